// ### rtl/sleep_ctrl_regs.svh
// Register offsets, field positions, reset values and timing counts of the sleep controller.
`ifndef SLEEP_CTRL_REGS_SVH
`define SLEEP_CTRL_REGS_SVH
`define SLP_OFF_SLEEP_CONTROL   8'h00
`define SLP_OFF_BROWNOUT_CTRL   8'h04
`define SLP_OFF_GATING          8'h08
`define SLP_OFF_STATUS          8'h0C
`define SLP_OFF_WAKE_CFG        8'h10
`define SLP_BIT_ARM             0
`define SLP_BIT_MODE_LO         1
`define SLP_BIT_MODE_HI         2
`define SLP_BIT_BOD_OFF         6
`define SLP_BIT_BOD_UNLOCK      5
`define SLP_RESET_CONTROL       3'h0
`define SLP_RESET_GATING        8'h00
`define SLP_UNLOCK_WINDOW       3'h4
`define SLP_BOD_ACTIVE_DELAY    3'h3
`define SLP_BOD_ACTIVE_HOLD     3'h3
`define SLP_HALT_EXTRA          4
`define SLP_CLK_MHZ             25
`define SLP_BOD_WAKE_US         60
`define SLP_BOD_WAKE_CYCLES     (`SLP_BOD_WAKE_US * `SLP_CLK_MHZ)
`define SLP_FUSE_TIMEOUT_DFLT   16
`endif

// ### rtl/sleep_ctrl_pkg.sv
// Types shared by the sleep controller.
package sleep_ctrl_pkg;
   typedef enum logic [1:0] {
      MODE_IDLE       = 2'h0,
      MODE_ADC_NR     = 2'h1,
      MODE_POWER_DOWN = 2'h2,
      MODE_POWER_SAVE = 2'h3
   } sleep_mode_t;

   typedef enum logic [3:0] {
      ST_ACTIVE = 4'h1,
      ST_SLEEP  = 4'h2,
      ST_START  = 4'h4,
      ST_HALT   = 4'h8
   } sleep_state_t;

   // Wake events as seen by the controller.
   typedef struct packed {
      logic adc_done;
      logic ext_reset;
      logic wdt_reset;
      logic wdt_irq;
      logic bod_reset;
      logic serial_start;
      logic async_timer_irq;
      logic mem_ready;
      logic ext_irq_a;
      logic ext_irq_b;
      logic pin_change;
      logic timer_ovf;
      logic timer_cmp;
      logic other_io;
   } wake_src_t;

   typedef struct packed {
      logic core;
      logic flash;
      logic io;
      logic adc;
      logic async_timer;
      logic main_osc;
   } clk_en_t;
endpackage : sleep_ctrl_pkg

// ### rtl/sleep_mode_controller.sv
// Sleep mode controller with AXI4-Lite register access.
`include "sleep_ctrl_regs.svh"
`timescale 1ns/1ps
`default_nettype none

// What this block does
// RULE1 - Sleep only when armed and instruction executes
// RULE2 - Mode 00 Idle stops core, flash clocks
// RULE3 - Mode 01 stops io, core, flash clocks
// RULE4 - Noise reduction wakes on listed events only
// RULE5 - Mode 10 power-down stops all generated clocks
// RULE6 - Power-down wakes on listed events only
// RULE7 - Outside Idle, external lines wake level-only
// RULE8 - Mode 11 like power-down, async clock runs
// RULE9 - Power-save timer wake needs mask and global
// RULE10 - Interrupt wake halts four extra cycles
// RULE11 - Memory kept; reset in sleep wakes core
// RULE12 - Idle or noise mode starts enabled conversion
// RULE13 - Brownout off in deep sleep, on at wake
// RULE14 - Brownout-off sleep wakes after about 60us
// RULE15 - Brownout sleep-off bit resets to zero
// RULE16 - Power-down wake delay equals fuse timeout
// RULE17 - External level must stay until wake
// RULE18 - Software picks power-down without async timer
// RULE19 - Gating bit stops clock, blocks register access
// RULE20 - Clearing gating bit restarts clock unchanged
// RULE21 - Gating acts in Active and Idle
// RULE22 - Timed unlock sequence sets sleep-off bit
// RULE23 - Sleep-off active after three, clears after three
// RULE24 - Unarmed sleep instruction is no-operation
// RULE25 - Unlisted wake sources are ignored
module sleep_mode_controller #(
   parameter int unsigned BOD_WAKE_CYCLES = `SLP_BOD_WAKE_CYCLES
) (
   input  wire  logic                     i_clk,
   input  wire  logic                     i_reset,
   input  wire  logic [31:0]              s_axi_awaddr,
   input  wire  logic                     s_axi_awvalid,
   output logic                           s_axi_awready,
   input  wire  logic [31:0]              s_axi_wdata,
   input  wire  logic [3:0]               s_axi_wstrb,
   input  wire  logic                     s_axi_wvalid,
   output logic                           s_axi_wready,
   output logic [1:0]                     s_axi_bresp,
   output logic                           s_axi_bvalid,
   input  wire  logic                     s_axi_bready,
   input  wire  logic [31:0]              s_axi_araddr,
   input  wire  logic                     s_axi_arvalid,
   output logic                           s_axi_arready,
   output logic [31:0]                    s_axi_rdata,
   output logic [1:0]                     s_axi_rresp,
   output logic                           s_axi_rvalid,
   input  wire  logic                     s_axi_rready,
   input  wire  logic                     i_sleep_instr,
   input  wire  sleep_ctrl_pkg::wake_src_t i_wake,
   input  wire  logic                     i_ext_a_level_mode,
   input  wire  logic                     i_ext_b_level_mode,
   input  wire  logic                     i_timer_async_select,
   input  wire  logic [1:0]               i_timer_irq_mask,
   input  wire  logic                     i_global_irq_enable,
   input  wire  logic                     i_adc_enabled,
   input  wire  logic [15:0]              i_clock_source_fuses_timeout,
   output sleep_ctrl_pkg::clk_en_t        o_clk_en,
   output logic [7:0]                     o_periph_clk_en,
   output logic [7:0]                     o_periph_access_en,
   output logic                           o_adc_start,
   output logic                           o_brownout_detector_en,
   output logic                           o_core_halted,
   output logic                           o_irq_wake,
   output logic                           o_reset_wake
);

   ////////////////////////////////////////////////////////////////////////////
   // Register file.
   logic                          sleep_arm_bit;
   sleep_ctrl_pkg::sleep_mode_t   sleep_mode_select;
   logic [7:0]                    peripheral_gating_reg;
   logic                          brownout_sleep_off;
   logic                          brownout_sleep_off_unlock;
   logic [2:0]                    unlock_cnt;
   logic [2:0]                    bod_cnt;
   logic                          bod_active;
   sleep_ctrl_pkg::sleep_state_t  state;
   sleep_ctrl_pkg::sleep_mode_t   cur_mode;
   logic                          bod_was_off;
   logic                          wake_by_reset;
   logic [31:0]                   delay_cnt;
   logic [31:0]                   wake_delay;

   logic        aw_held;
   logic        w_held;
   logic [7:0]  aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        do_write;
   logic [7:0]  ar_addr;

   function automatic logic addr_mapped(input logic [7:0] a);
      addr_mapped = (a == `SLP_OFF_SLEEP_CONTROL) || (a == `SLP_OFF_BROWNOUT_CTRL) ||
                    (a == `SLP_OFF_GATING) || (a == `SLP_OFF_STATUS) || (a == `SLP_OFF_WAKE_CFG);
   endfunction : addr_mapped

   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign do_write      = aw_held && w_held && !s_axi_bvalid;

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_addr <= 8'h00;
         w_data  <= 32'h0000_0000;
         w_strb  <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr[7:0];
         end else if (do_write) begin
            aw_held <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end else if (do_write) begin
            w_held <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'h0;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= addr_mapped(aw_addr) ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   assign ar_addr = s_axi_araddr[7:0];

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= 2'h0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= addr_mapped(ar_addr) ? 2'h0 : 2'h2;
         case (ar_addr)
            `SLP_OFF_SLEEP_CONTROL: s_axi_rdata <= {29'h0, sleep_mode_select, sleep_arm_bit};
            `SLP_OFF_BROWNOUT_CTRL: s_axi_rdata <= {25'h0, bod_active, brownout_sleep_off_unlock, 5'h0};
            `SLP_OFF_GATING:        s_axi_rdata <= {24'h0, peripheral_gating_reg};
            `SLP_OFF_STATUS:        s_axi_rdata <= {26'h0, bod_was_off, wake_by_reset, state};
            `SLP_OFF_WAKE_CFG:      s_axi_rdata <= wake_delay;
            default:                s_axi_rdata <= 32'h0000_0000;
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         sleep_arm_bit         <= 1'b0;
         sleep_mode_select     <= sleep_ctrl_pkg::MODE_IDLE;
         peripheral_gating_reg <= `SLP_RESET_GATING;
      end else if (do_write && w_strb[0]) begin
         if (aw_addr == `SLP_OFF_SLEEP_CONTROL) begin
            sleep_arm_bit     <= w_data[`SLP_BIT_ARM];
            sleep_mode_select <= sleep_ctrl_pkg::sleep_mode_t'(w_data[`SLP_BIT_MODE_HI:`SLP_BIT_MODE_LO]);
         end
         if (aw_addr == `SLP_OFF_GATING) begin
            peripheral_gating_reg <= w_data[7:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Timed brownout sleep-off sequence.
   logic bod_wr;
   assign bod_wr = do_write && w_strb[0] && (aw_addr == `SLP_OFF_BROWNOUT_CTRL);

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         brownout_sleep_off_unlock <= 1'b0;
         unlock_cnt                <= 3'h0;
      end else if (bod_wr && w_data[`SLP_BIT_BOD_OFF] && w_data[`SLP_BIT_BOD_UNLOCK]) begin
         brownout_sleep_off_unlock <= 1'b1;                       // [RULE22]
         unlock_cnt                <= `SLP_UNLOCK_WINDOW;
      end else if (unlock_cnt != 3'h0) begin
         unlock_cnt <= unlock_cnt - 3'h1;
         if (unlock_cnt == 3'h1 || bod_wr) begin
            brownout_sleep_off_unlock <= 1'b0;
         end
      end
   end

   // The sleep-off bit counts three cycles pending, then three cycles active.
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         brownout_sleep_off <= 1'b0;                               // [RULE15]
         bod_cnt            <= 3'h0;
         bod_active         <= 1'b0;
      end else if (bod_wr && brownout_sleep_off_unlock && w_data[`SLP_BIT_BOD_OFF]
                   && !w_data[`SLP_BIT_BOD_UNLOCK]) begin
         brownout_sleep_off <= 1'b1;                               // [RULE22]
         bod_cnt            <= `SLP_BOD_ACTIVE_DELAY;
         bod_active         <= 1'b0;
      end else if (bod_cnt != 3'h0) begin
         bod_cnt <= bod_cnt - 3'h1;
         if (bod_cnt == 3'h1) begin
            if (!bod_active) begin
               bod_active <= 1'b1;                                 // [RULE23]
               bod_cnt    <= `SLP_BOD_ACTIVE_HOLD;
            end else begin
               bod_active         <= 1'b0;                         // [RULE23]
               brownout_sleep_off <= 1'b0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Wake qualification.
   logic ext_a_ok;
   logic ext_b_ok;
   logic any_reset;
   logic wake_ok;
   logic deep_mode;
   logic enter;

   assign ext_a_ok  = i_wake.ext_irq_a && (cur_mode == sleep_ctrl_pkg::MODE_IDLE || i_ext_a_level_mode); // [RULE7]
   assign ext_b_ok  = i_wake.ext_irq_b && (cur_mode == sleep_ctrl_pkg::MODE_IDLE || i_ext_b_level_mode); // [RULE7]
   assign any_reset = i_wake.ext_reset || i_wake.wdt_reset || i_wake.bod_reset;
   assign deep_mode = cur_mode[1];
   assign enter     = (state == sleep_ctrl_pkg::ST_ACTIVE) && i_sleep_instr && sleep_arm_bit; // [RULE1] [RULE24]

   always_comb begin
      wake_ok = 1'b0;
      case (cur_mode)
         sleep_ctrl_pkg::MODE_IDLE:
            wake_ok = (|i_wake) || ext_a_ok;
         sleep_ctrl_pkg::MODE_ADC_NR:
            wake_ok = i_wake.adc_done || i_wake.wdt_irq || i_wake.serial_start || i_wake.async_timer_irq
                      || i_wake.mem_ready || ext_a_ok || ext_b_ok || i_wake.pin_change; // [RULE4] [RULE25]
         sleep_ctrl_pkg::MODE_POWER_DOWN:
            wake_ok = i_wake.wdt_irq || i_wake.serial_start || ext_a_ok || ext_b_ok
                      || i_wake.pin_change;                        // [RULE6] [RULE25]
         sleep_ctrl_pkg::MODE_POWER_SAVE:
            wake_ok = i_wake.wdt_irq || i_wake.serial_start || ext_a_ok || ext_b_ok || i_wake.pin_change
                      || (i_timer_async_select && i_global_irq_enable
                          && ((i_wake.timer_ovf && i_timer_irq_mask[0])
                              || (i_wake.timer_cmp && i_timer_irq_mask[1])));   // [RULE9]
         default:
            wake_ok = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sleep state machine.
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         state         <= sleep_ctrl_pkg::ST_ACTIVE;
         cur_mode      <= sleep_ctrl_pkg::MODE_IDLE;
         bod_was_off   <= 1'b0;
         wake_by_reset <= 1'b0;
         delay_cnt     <= 32'h0000_0000;
      end else begin
         case (state)
            sleep_ctrl_pkg::ST_ACTIVE: begin
               if (enter) begin
                  state       <= sleep_ctrl_pkg::ST_SLEEP;
                  cur_mode    <= sleep_mode_select;
                  bod_was_off <= bod_active && sleep_mode_select[1]; // [RULE13]
               end
            end
            sleep_ctrl_pkg::ST_SLEEP: begin
               if (any_reset) begin
                  state         <= sleep_ctrl_pkg::ST_START;       // [RULE11]
                  wake_by_reset <= 1'b1;
                  delay_cnt     <= wake_delay;
               end else if (wake_ok) begin
                  state         <= sleep_ctrl_pkg::ST_START;
                  wake_by_reset <= 1'b0;
                  delay_cnt     <= wake_delay;
               end
            end
            sleep_ctrl_pkg::ST_START: begin
               if (delay_cnt > 32'h0000_0001) begin
                  delay_cnt <= delay_cnt - 32'h0000_0001;
               end else begin
                  state       <= sleep_ctrl_pkg::ST_HALT;
                  delay_cnt   <= 32'(`SLP_HALT_EXTRA);             // [RULE10]
                  bod_was_off <= 1'b0;
               end
            end
            sleep_ctrl_pkg::ST_HALT: begin
               if (delay_cnt > 32'h0000_0001) begin
                  delay_cnt <= delay_cnt - 32'h0000_0001;
               end else begin
                  state <= sleep_ctrl_pkg::ST_ACTIVE;
               end
            end
            default: state <= sleep_ctrl_pkg::ST_ACTIVE;
         endcase
      end
   end

   // Deep modes restart the oscillator, so they pay the fuse timeout; a silenced detector raises the delay to at least BOD_WAKE_CYCLES.
   always_comb begin
      wake_delay = 32'h0000_0001;
      if (deep_mode) begin
         wake_delay = {16'h0000, i_clock_source_fuses_timeout};     // [RULE16]
      end
      if (bod_was_off && BOD_WAKE_CYCLES > wake_delay) begin
         wake_delay = BOD_WAKE_CYCLES;                              // [RULE14]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Clock enables and side outputs.
   logic asleep;
   assign asleep = (state == sleep_ctrl_pkg::ST_SLEEP);

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_clk_en <= '1;
      end else begin
         o_clk_en <= '1;                                           // [RULE24]
         if (asleep || enter) begin
            case (enter ? sleep_mode_select : cur_mode)
               sleep_ctrl_pkg::MODE_IDLE:
                  o_clk_en <= 6'b00_1111;                          // [RULE2]
               sleep_ctrl_pkg::MODE_ADC_NR:
                  o_clk_en <= 6'b00_0111;                          // [RULE3]
               sleep_ctrl_pkg::MODE_POWER_DOWN:
                  o_clk_en <= 6'b00_0000;                          // [RULE5]
               sleep_ctrl_pkg::MODE_POWER_SAVE:
                  o_clk_en <= 6'b00_0010;                          // [RULE8]
               default:
                  o_clk_en <= '1;
            endcase
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_gate
         // The clock stops and register access is blocked; peripheral state is untouched, so ungating resumes it as it was.
         assign o_periph_clk_en[g]    = !peripheral_gating_reg[g] && o_clk_en.io;  // [RULE19] [RULE20] [RULE21]
         assign o_periph_access_en[g] = !peripheral_gating_reg[g];                 // [RULE19]
      end
   endgenerate

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_adc_start            <= 1'b0;
         o_brownout_detector_en <= 1'b1;
      end else begin
         o_adc_start            <= enter && i_adc_enabled && !sleep_mode_select[1]; // [RULE12]
         o_brownout_detector_en <= !(asleep && bod_was_off);                       // [RULE13]
      end
   end

   assign o_core_halted = (state != sleep_ctrl_pkg::ST_ACTIVE);
   assign o_irq_wake    = (state == sleep_ctrl_pkg::ST_HALT) && (delay_cnt == 32'h0000_0001) && !wake_by_reset;
   assign o_reset_wake  = (state == sleep_ctrl_pkg::ST_HALT) && (delay_cnt == 32'h0000_0001) && wake_by_reset;

   ////////////////////////////////////////////////////////////////////////////
   // Checks.
   property p_enter;
      @(posedge i_clk) disable iff (i_reset)
      (state == sleep_ctrl_pkg::ST_ACTIVE && i_sleep_instr && sleep_arm_bit) |=> asleep;
   endproperty
   a_enter: assert property (p_enter) else $error("sleep not entered"); // [RULE1]

   property p_noarm;
      @(posedge i_clk) disable iff (i_reset)
      (state == sleep_ctrl_pkg::ST_ACTIVE && !sleep_arm_bit) |=> !asleep;
   endproperty
   a_noarm: assert property (p_noarm) else $error("unarmed sleep entered"); // [RULE24]

   property p_idle_clk;
      @(posedge i_clk) disable iff (i_reset)
      (asleep && cur_mode == sleep_ctrl_pkg::MODE_IDLE) |-> (!o_clk_en.core && o_clk_en.io);
   endproperty
   a_idle_clk: assert property (p_idle_clk) else $error("idle clocks wrong"); // [RULE2]

   property p_pd_clk;
      @(posedge i_clk) disable iff (i_reset)
      (asleep && cur_mode == sleep_ctrl_pkg::MODE_POWER_DOWN) |-> (o_clk_en == 6'b00_0000);
   endproperty
   a_pd_clk: assert property (p_pd_clk) else $error("power-down clocks running"); // [RULE5]

   property p_pd_ignore;
      @(posedge i_clk) disable iff (i_reset)
      (asleep && cur_mode == sleep_ctrl_pkg::MODE_POWER_DOWN && !any_reset && !i_wake.wdt_irq
       && !i_wake.serial_start && !ext_a_ok && !ext_b_ok && !i_wake.pin_change) |=> asleep;
   endproperty
   a_pd_ignore: assert property (p_pd_ignore) else $error("unlisted wake"); // [RULE6]

   property p_halt4;
      @(posedge i_clk) disable iff (i_reset)
      $rose(state == sleep_ctrl_pkg::ST_HALT) |-> o_core_halted [*4] ##1 !o_core_halted;
   endproperty
   a_halt4: assert property (p_halt4) else $error("halt length wrong"); // [RULE10]

   property p_bod_seq;
      @(posedge i_clk) disable iff (i_reset)
      $rose(brownout_sleep_off) |-> !bod_active [*3] ##1 bod_active [*3] ##1 !brownout_sleep_off;
   endproperty
   a_bod_seq: assert property (p_bod_seq) else $error("sleep-off timing wrong"); // [RULE23]

   property p_bod_off;
      @(posedge i_clk) disable iff (i_reset)
      (asleep && bod_was_off) |=> (!o_brownout_detector_en || !asleep);
   endproperty
   a_bod_off: assert property (p_bod_off) else $error("detector not off"); // [RULE13]

   property p_adc;
      @(posedge i_clk) disable iff (i_reset)
      (enter && i_adc_enabled && !sleep_mode_select[1]) |=> o_adc_start;
   endproperty
   a_adc: assert property (p_adc) else $error("no conversion start"); // [RULE12]

   c_idle:  cover property (@(posedge i_clk) enter && sleep_mode_select == sleep_ctrl_pkg::MODE_IDLE);
   c_save:  cover property (@(posedge i_clk) asleep && cur_mode == sleep_ctrl_pkg::MODE_POWER_SAVE && wake_ok);
   c_rst:   cover property (@(posedge i_clk) o_reset_wake);
   c_bodoff: cover property (@(posedge i_clk) asleep && bod_was_off);

endmodule : sleep_mode_controller
`default_nettype wire

// ### dv/core_irq_model.sv
// Behavioural model of the core and the interrupt sources facing the sleep controller.
`timescale 1ns/1ps
`default_nettype none
module core_irq_model (
   input  wire  logic                 i_clk,
   input  wire  logic                 i_reset,
   input  wire  logic                 i_sleep_req,
   input  wire  logic [13:0]          i_wake_req,
   input  wire  logic                 i_halted,
   output logic                       o_sleep_instr,
   output sleep_ctrl_pkg::wake_src_t  o_wake
);
   always_ff @(posedge i_clk) begin
      o_sleep_instr <= i_sleep_req & ~i_reset;
   end
   // A wake level stays up until the core runs again, so a slow start-up still sees it.
   always_ff @(posedge i_clk) begin
      if (i_reset) o_wake <= '0;
      else if (i_wake_req != 14'h0000) o_wake <= i_wake_req;
      else if (!i_halted) o_wake <= '0;
   end
endmodule : core_irq_model
`default_nettype wire

// ### dv/test_sleep_mode_controller.sv
// Self-checking testbench of the sleep mode controller.
`timescale 1ns/1ps
`default_nettype none
module test_sleep_mode_controller;
   logic i_clk = 0, i_reset = 1, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, slp = 0, i_ext = 1, adce = 0;
   logic bod_en, rst_wake;
   logic [15:0] fuse = 16'h0008;
   logic [31:0] awa = 0, wd = 0, ara = 0, rd, s_axi_rdata;
   logic [13:0] wreq = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, i_sleep_instr;
   logic o_core_halted, o_irq_wake, o_adc_start;
   logic [1:0] s_axi_bresp, s_axi_rresp, rr;
   logic [7:0] pclk, pacc;
   sleep_ctrl_pkg::wake_src_t i_wake;
   sleep_ctrl_pkg::clk_en_t o_clk_en;
   int mismatches = 0, check_count = 0, adc_n = 0;
   logic [5:0] exp_clk [4] = '{6'h0F, 6'h07, 6'h00, 6'h02};
   initial forever #20 i_clk = ~i_clk;
   always @(posedge i_clk) if (o_adc_start === 1'b1) adc_n++;
   core_irq_model partner (.i_clk(i_clk), .i_reset(i_reset), .i_sleep_req(slp), .i_wake_req(wreq),
      .i_halted(o_core_halted), .o_sleep_instr(i_sleep_instr), .o_wake(i_wake));
   sleep_mode_controller #(.BOD_WAKE_CYCLES(20)) dut (.i_clk(i_clk), .i_reset(i_reset),
      .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(s_axi_awready), .s_axi_wdata(wd),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(rre), .i_sleep_instr(i_sleep_instr), .i_wake(i_wake),
      .i_ext_a_level_mode(i_ext), .i_ext_b_level_mode(i_ext), .i_timer_async_select(1'b1),
      .i_timer_irq_mask(2'h3), .i_global_irq_enable(1'b1), .i_adc_enabled(adce),
      .i_clock_source_fuses_timeout(fuse), .o_clk_en(o_clk_en), .o_periph_clk_en(pclk),
      .o_periph_access_en(pacc), .o_adc_start(o_adc_start), .o_brownout_detector_en(bod_en),
      .o_core_halted(o_core_halted), .o_irq_wake(o_irq_wake), .o_reset_wake(rst_wake));
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ra, rw, b;
      awa <= {24'h0000_00, a}; wd <= d; awv <= 1; wv <= 1; bre <= 1;
      ra = 0; rw = 0;
      do begin
         @(negedge i_clk); ra = ra | (awv & s_axi_awready); rw = rw | (wv & s_axi_wready);
         @(posedge i_clk); if (ra) awv <= 0; if (rw) wv <= 0;
      end while (!(ra & rw));
      do begin @(negedge i_clk); b = s_axi_bvalid; @(posedge i_clk); end while (!b);
      bre <= 0;
      @(posedge i_clk);
   endtask : wr
   task automatic rdreg(input logic [7:0] a);
      logic r;
      ara <= {24'h0000_00, a}; arv <= 1; rre <= 1;
      do begin @(negedge i_clk); r = s_axi_arready; @(posedge i_clk); end while (!r);
      arv <= 0;
      do begin @(negedge i_clk); r = s_axi_rvalid; rd = s_axi_rdata; rr = s_axi_rresp; @(posedge i_clk); end
      while (!r);
      rre <= 0;
      @(posedge i_clk);
   endtask : rdreg
   task automatic sleep_once(input logic [2:0] ctl);
      wr(8'h00, {29'h0, ctl});
      slp <= 1; @(posedge i_clk); slp <= 0;
      repeat (4) @(posedge i_clk);
   endtask : sleep_once
   task automatic wake_up(input logic [13:0] src, output int n, output logic wi, output logic wrs);
      wreq <= src; @(posedge i_clk); wreq <= 0;
      n = 0; wi = 0; wrs = 0;
      while (o_core_halted !== 1'b0 && n < 200) begin
         @(posedge i_clk); n++; wi = wi | (o_irq_wake === 1'b1); wrs = wrs | (rst_wake === 1'b1);
      end
   endtask : wake_up
   task automatic run_modes();
      int n, a0;
      logic w, r;
      for (int m = 0; m < 4; m++) begin
         // Each deep mode gets its own fuse timeout, so the wake delay is seen to follow the input.
         a0 = adc_n; adce <= m[0]; fuse <= 16'h0006 + 16'(m);
         sleep_once({m[1:0], 1'b1});
         chk("clk_en", {26'h0, o_clk_en}, {26'h0, exp_clk[m]});
         chk("adc_start", adc_n - a0, (m == 1) ? 1 : 0);
         if (m != 0) begin
            wreq <= 14'h0001; @(posedge i_clk); wreq <= 0;
            repeat (12) @(posedge i_clk);
            chk("halted", {31'h0, o_core_halted}, 1);
         end
         wake_up((m == 3) ? 14'h0004 : 14'h0008, n, w, r);
         chk("wake_cycles", n, ((m >= 2) ? 6 + m : 1) + 6);
         chk("irq_wake", {30'h0, w, r}, 2);
         chk("clk_back", {26'h0, o_clk_en}, 32'h0000_003F);
      end
   endtask : run_modes
   task automatic bod_sleep();
      int n;
      logic w, r;
      wr(8'h00, 32'h0000_0005);
      wr(8'h04, 32'h0000_0060);
      wr(8'h04, 32'h0000_0040);
      slp <= 1; @(posedge i_clk); slp <= 0;
      repeat (4) @(posedge i_clk);
      chk("bod_en_sleep", {31'h0, bod_en}, 0);
      rdreg(8'h10); chk("bod_delay", rd, 20);
      rdreg(8'h0C); chk("status", rd, 32'h0000_0022);
      wake_up(14'h1000, n, w, r);
      chk("reset_wake", {30'h0, w, r}, 1);
      chk("bod_cycles", n, 20 + 6);
      chk("bod_en_back", {31'h0, bod_en}, 1);
   endtask : bod_sleep
   task automatic misc();
      rdreg(8'h04); chk("bod_reset", rd & 32'h0000_0060, 0);
      rdreg(8'h40); chk("unmapped", {30'h0, rr}, 2);
      sleep_once(3'h4);
      chk("nop", {25'h0, o_core_halted, o_clk_en}, 32'h0000_003F);
      wr(8'h08, 32'h0000_0005); @(posedge i_clk);
      chk("gate", {pclk, pacc}, 32'h0000_FAFA);
      wr(8'h08, 32'h0000_0000); @(posedge i_clk);
      chk("ungate", {pclk, pacc}, 32'h0000_FFFF);
   endtask : misc
   task automatic results();
      if (mismatches == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : results
   initial begin
      repeat (3) @(posedge i_clk);
      i_reset <= 0;
      @(posedge i_clk);
      misc();
      run_modes();
      bod_sleep();
      results();
   end
   initial begin
      #2ms;
      mismatches++;
      results();
   end
endmodule : test_sleep_mode_controller
`default_nettype wire
